// [pef_regs.vh]
`ifndef PEF_REGS_VH
`define PEF_REGS_VH
// ==========================================
// register byte offsets
`define PEF_FLAGS_OFF     8'h00
`define PEF_CLEAR_OFF     8'h04
`define PEF_ENABLE_OFF    8'h08
`define PEF_MODE_OFF      8'h0C
// ==========================================
// flag bit positions
`define PEF_BIT_OVF       0
`define PEF_BIT_PERIOD    1
`define PEF_BIT_CAPCMP    2
`define PEF_BIT_UNIMPL    3
`define PEF_BIT_TXEMPTY   4
// ==========================================
// reset values and capture/compare modes
`define PEF_FLAGS_RST     5'h00
`define PEF_ENABLE_RST    5'h00
`define PEF_MODE_RST      2'h0
`define PEF_MODE_OFF_SEL  2'h0
`define PEF_MODE_CAPTURE  2'h1
`define PEF_MODE_COMPARE  2'h2
`define PEF_MODE_PWM      2'h3
`define PEF_IMPL_MASK     5'h17
`endif

// [pef_flags.v]
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - transmit flag bit 4 reads 1 when buffer empty, 0 when full
// - bit 3 unimplemented: reads 0, writes ignored
// - capture mode: capture event sets bit 2, held until software clears
// - compare mode: match sets bit 2 held; PWM mode leaves bit 2 unused
// - short timer count equals period sets bit 1, held until cleared
`include "pef_regs.vh"
module pef_flags (
  // clock and reset
  input  wire        clk,
  input  wire        resetn,
  // event sources, same clock domain, one-cycle strobes except txBufferEmpty, a live level
  input  wire        txBufferEmpty,
  input  wire        captureEvent,
  input  wire        compareMatch,
  input  wire        periodMatch,
  input  wire        wideOverflow,
  // axi4-lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt and status
  output wire        irq,
  output wire [7:0]  peripheralEventFlags
);
  // ==========================================
  // state
  reg  [4:0] flags;
  reg  [4:0] enable;
  reg  [1:0] capcmpMode;
  reg        awHeld;
  reg        wHeld;
  reg  [7:0] awAddr;
  reg [31:0] wData;
  reg  [3:0] wStrb;
  wire [4:0] liveFlags;
  wire [4:0] setEvents;
  wire [4:0] clearMask;
  wire       doWrite;
  // ==========================================
  // flag view
  // bit 4 is live buffer state, not latched, so software cannot clear it
  assign liveFlags = {txBufferEmpty, 1'b0, flags[2:0]};
  assign peripheralEventFlags = {3'h0, liveFlags};
  assign irq = |(liveFlags & enable);
  // ==========================================
  // write channel: address and data taken in either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h00000000;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr[7:2])
          6'h00, 6'h01, 6'h02, 6'h03: s_axi_bresp <= 2'h0;
          default:                    s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ==========================================
  // flag and control registers
  // set wins over a clear landing in the same cycle
  assign clearMask = (doWrite && awAddr == `PEF_CLEAR_OFF && wStrb[0]) ?
                     (wData[4:0] & `PEF_IMPL_MASK) : 5'h00;
  assign setEvents[`PEF_BIT_OVF]     = wideOverflow;
  assign setEvents[`PEF_BIT_PERIOD]  = periodMatch;
  assign setEvents[`PEF_BIT_CAPCMP]  =
    (capcmpMode == `PEF_MODE_CAPTURE && captureEvent) ||
    (capcmpMode == `PEF_MODE_COMPARE && compareMatch);
  assign setEvents[`PEF_BIT_UNIMPL]  = 1'b0;
  assign setEvents[`PEF_BIT_TXEMPTY] = 1'b0;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags      <= `PEF_FLAGS_RST;
      enable     <= `PEF_ENABLE_RST;
      capcmpMode <= `PEF_MODE_RST;
    end else begin
      flags <= ((flags & ~clearMask) | setEvents) & 5'h07;
      if (doWrite && wStrb[0] && awAddr == `PEF_ENABLE_OFF)
        enable <= wData[4:0] & `PEF_IMPL_MASK;
      if (doWrite && wStrb[0] && awAddr == `PEF_MODE_OFF)
        capcmpMode <= wData[1:0];
    end
  end
  // ==========================================
  // read channel, one cycle after address accepted
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        `PEF_FLAGS_OFF:  s_axi_rdata <= {27'h0, liveFlags};
        `PEF_CLEAR_OFF:  s_axi_rdata <= 32'h00000000;
        `PEF_ENABLE_OFF: s_axi_rdata <= {27'h0, enable};
        `PEF_MODE_OFF:   s_axi_rdata <= {30'h0, capcmpMode};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pef_flags

// [pef_flags_props.sv]
`timescale 1ns/1ps
module pef_flags_chk (
  // clock, reset, sources, bus
  input wire       clk, resetn, txBufferEmpty,
  input wire       captureEvent, compareMatch, periodMatch, wideOverflow,
  input wire       s_axi_bvalid,
  input wire [7:0] peripheralEventFlags
);
  wire [7:0] f = peripheralEventFlags;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_tx_live: assert property (f[4] == txBufferEmpty)
    else $error("tx flag differs from buffer state");
  a_bit_three: assert property (f[3] == 1'b0)
    else $error("unused bit reads one");
  a_capcmp_cause: assert property ($rose(f[2]) |-> $past(captureEvent | compareMatch))
    else $error("capture flag set without event");
  a_period_set: assert property (periodMatch |=> f[1])
    else $error("period flag not set");
  a_ovf_set: assert property (wideOverflow |=> f[0])
    else $error("overflow flag not set");
  // sticky flags drop only at the edge where a write lands, which raises bvalid
  a_sticky_clear: assert property (|($past(f[2:0]) & ~f[2:0]) |-> $rose(s_axi_bvalid))
    else $error("flag dropped without write");
endmodule // pef_flags_chk
bind pef_flags pef_flags_chk u_chk (.*);

// [testbench.sv]
`timescale 1ns/1ps
`include "pef_regs.vh"
module testbench;
  logic        clk = 0, resetn = 0, txBufferEmpty = 0, irq, ta, tw, tb;
  logic        captureEvent = 0, compareMatch = 0, periodMatch = 0, wideOverflow = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, peripheralEventFlags;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          n_fail = 0, cmp_count = 0, cyc = 0, m, e;
  pef_flags u_dut (.*);
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (++cyc > 3000) begin n_fail++; stop_test; end
  task stop_test; begin
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish; end endtask
  task chk(input string n, input logic [31:0] x, g); begin
    cmp_count++;
    if (g !== x) begin n_fail++; $display("unexpected %s exp %h got %h", n, x, g); end
  end endtask
  // handshakes are judged at the falling edge, where readies equal the next rising edge
  task wr(input [7:0] a, input [31:0] d); begin
    @(posedge clk); s_axi_awaddr <= a; s_axi_wdata <= d;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(negedge clk); ta = s_axi_awready & s_axi_awvalid; tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid; rs = s_axi_bresp;
      @(posedge clk); if (ta) s_axi_awvalid <= 0; if (tw) s_axi_wvalid <= 0;
    end while (!tb);
    s_axi_bready <= 0; end endtask
  task rdr(input [7:0] a); begin
    @(posedge clk); s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(negedge clk); ta = s_axi_arready & s_axi_arvalid; tb = s_axi_rvalid;
      rd = s_axi_rdata; rs = s_axi_rresp; @(posedge clk); if (ta) s_axi_arvalid <= 0;
    end while (!tb);
    s_axi_rready <= 0; end endtask
  task pulse(input [3:0] v); begin
    @(posedge clk); {captureEvent, compareMatch, periodMatch, wideOverflow} <= v;
    @(posedge clk); {captureEvent, compareMatch, periodMatch, wideOverflow} <= 0;
    @(negedge clk); end endtask
  initial begin
    void'($urandom(565));
    repeat (2) @(posedge clk); resetn <= 1;
    for (m = 0; m < 8; m++) begin
      @(posedge clk) txBufferEmpty <= $urandom % 2; @(negedge clk);
      chk("flags", {3'h0, txBufferEmpty, 4'h0}, peripheralEventFlags);
    end
    rdr(`PEF_FLAGS_OFF); chk("flags read", {27'h0, txBufferEmpty, 4'h0}, rd);
    @(posedge clk) txBufferEmpty <= 0;
    for (m = 0; m < 4; m++) for (e = 0; e < 2; e++) begin
      wr(`PEF_MODE_OFF, m); wr(`PEF_CLEAR_OFF, 7); pulse(e ? 4'h4 : 4'h8);
      rdr(`PEF_FLAGS_OFF); chk("capcmp", (m == e + 1) << 2, rd);
    end
    wr(`PEF_CLEAR_OFF, 7); pulse(4'h3); repeat ($urandom % 5) @(posedge clk); @(negedge clk);
    chk("sticky", 8'h03, peripheralEventFlags);
    wr(`PEF_ENABLE_OFF, 1); @(negedge clk); chk("irq on", 1, irq);
    wr(`PEF_ENABLE_OFF, 8'h1C); @(negedge clk); chk("irq masked", 0, irq);
    rdr(`PEF_ENABLE_OFF); chk("enable read", 32'h14, rd);
    rdr(`PEF_MODE_OFF); chk("mode read", 3, rd);
    wr(`PEF_FLAGS_OFF, 0); wr(`PEF_CLEAR_OFF, 1); @(negedge clk);
    chk("clear", 8'h02, peripheralEventFlags);
    wr(`PEF_ENABLE_OFF, 8'h10); @(posedge clk) txBufferEmpty <= 1; @(negedge clk);
    chk("irq tx", 1, irq);
    wr(8'h10, 0); chk("unmapped bresp", 2, rs);
    rdr(8'h10); chk("unmapped resp", 2, rs);
    stop_test;
  end
endmodule // testbench
